// ==== include/ccm_pkg.sv ====
// Purpose: constants and types for the capacitance and temperature correction datapath
// Assumes: fixed-point formats below are the block's own choice
// Notes: coefficients are signed 16-bit two's complement, except the unsigned reference temperature reading and region split point
package ccm_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // widths
  localparam int CAP_W_DEF = 14;
  localparam int TEMP_W = 14;
  localparam int COEF_W = 16;
  localparam int ACC_W = 48;
  localparam int DIV_W = 40;
  localparam int REM_W = 33;
  localparam logic [5:0] DIV_STEPS = 6'h28;

  ////////////////////////////////////////////////////////////////////////////
  // fixed-point fraction bits
  localparam int GAIN_FRAC = 14;
  localparam int DRIFT_LIN_FRAC = 16;
  localparam int DRIFT_SQ_FRAC = 16;
  localparam int DEN_FRAC = 14;
  localparam int NL_FRAC = 15;
  localparam int TEMP_GAIN_FRAC = 14;
  localparam int TEMP_SQ_FRAC = 24;

  ////////////////////////////////////////////////////////////////////////////
  // limits
  localparam logic signed [47:0] DEN_ONE = 48'sh0000_0000_4000;
  localparam logic signed [47:0] DEN_MIN = 48'sh0000_0000_0001;
  localparam logic signed [47:0] DEN_MAX = 48'sh0000_4000_0000;
  localparam logic signed [47:0] NUM_LIM = 48'sh0000_00FF_FFFF;
  localparam logic signed [47:0] TEMP_OUT_MIN = -48'sh0000_0000_8000;
  localparam logic signed [47:0] TEMP_OUT_MAX = 48'sh0000_0000_7FFF;
  localparam logic signed [47:0] ACC_MIN = 48'sh8000_0000_0000;
  localparam logic signed [47:0] ACC_MAX = 48'sh7FFF_FFFF_FFFF;

  ////////////////////////////////////////////////////////////////////////////
  // temperature resolution codes and raw masks
  localparam logic [1:0] TRES_8 = 2'h0;
  localparam logic [1:0] TRES_10 = 2'h1;
  localparam logic [1:0] TRES_12 = 2'h2;
  localparam logic [1:0] TRES_14 = 2'h3;
  localparam logic [13:0] TMASK_8 = 14'h00FF;
  localparam logic [13:0] TMASK_10 = 14'h03FF;
  localparam logic [13:0] TMASK_12 = 14'h0FFF;
  localparam logic [13:0] TMASK_14 = 14'h3FFF;

  ////////////////////////////////////////////////////////////////////////////
  // sequencer states
  typedef enum logic [2:0] {
    S_IDLE = 3'h1,
    S_DIV = 3'h2,
    S_POLY = 3'h4
  } ccm_state_t;

endpackage

// ==== hdl/ccm_correction_math.sv ====
// Purpose: corrects a raw capacitance and a raw temperature reading with loaded coefficients
// Assumes: coefficients stay stable from start until done
// Notes: one divider shared per run; a run takes 42 clock edges from start to done
//
// Operation
// RL1: two correction modes selectable: two-region piece-wise or single-region third order.
// RL2: adjusted reading is drift-corrected numerator divided by drift-corrected gain denominator.
// RL3: region one takes min(adjusted, split); region two takes max(0, adjusted minus split).
// RL4: two-region output sums square term plus linear term of each region.
// RL5: third order output uses cubic, square and linear terms of region one slope.
// RL6: single-region mode ignores second slope; second region adds nothing.
// RL7: delta-T is raw temperature minus reference, used for every drift term.
// RL8: corrected temperature is square, linear and offset polynomial of raw temperature.
// RL9: raw temperature unsigned to 16383; temperature coefficients signed 16-bit.
// RL10: corrected temperature clamped to -32768 through 32767.
// RL11: capacitance offset applied about the half full-scale point.
// RL12: loader keeps drift coefficients within their limits to protect the arithmetic; this block applies no such limit, sadd and mulsh saturate instead.
// RL13: resolution code selects raw temperature width of 8, 10, 12 or 14 bits.
// RL14: fixed-point arithmetic with saturation inside and clamped final outputs.
// RL15: start takes new readings; done pulses one cycle when both results valid; results held until the next done.
module ccm_correction_math #(
  parameter int CAP_W = ccm_pkg::CAP_W_DEF
) (
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst,
  // run control
  input wire logic i_start,
  input wire logic i_mode_cubic,
  input wire logic [1:0] i_temp_res,
  output logic o_busy,
  output logic o_done,
  // raw readings
  input wire logic [CAP_W-1:0] i_raw_cap,
  input wire logic [ccm_pkg::TEMP_W-1:0] i_raw_temp,
  // capacitance coefficients
  input wire logic signed [ccm_pkg::COEF_W-1:0] i_offset,
  input wire logic signed [ccm_pkg::COEF_W-1:0] i_offset_drift_linear,
  input wire logic signed [ccm_pkg::COEF_W-1:0] i_offset_drift_square,
  input wire logic signed [ccm_pkg::COEF_W-1:0] i_slope_drift_linear,
  input wire logic signed [ccm_pkg::COEF_W-1:0] i_slope_drift_square,
  input wire logic [ccm_pkg::TEMP_W-1:0] i_reference_temp_reading,
  input wire logic [CAP_W-1:0] i_region_split_point,
  input wire logic signed [ccm_pkg::COEF_W-1:0] i_first_region_slope,
  input wire logic signed [ccm_pkg::COEF_W-1:0] i_first_region_square_coef,
  input wire logic signed [ccm_pkg::COEF_W-1:0] i_second_region_slope,
  input wire logic signed [ccm_pkg::COEF_W-1:0] i_second_region_square_coef,
  // temperature coefficients
  input wire logic signed [ccm_pkg::COEF_W-1:0] i_temp_square_coef,
  input wire logic signed [ccm_pkg::COEF_W-1:0] i_temp_slope_coef,
  input wire logic signed [ccm_pkg::COEF_W-1:0] i_temp_offset_coef,
  // results
  output logic [CAP_W-1:0] o_corr_cap,
  output logic signed [ccm_pkg::COEF_W-1:0] o_corr_temp
);
  import ccm_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  // multiply then arithmetic shift, saturated to the accumulator range
  function automatic logic signed [ACC_W-1:0] mulsh(input logic signed [ACC_W-1:0] a,
                                                    input logic signed [ACC_W-1:0] b,
                                                    input int sh);
    logic signed [2*ACC_W-1:0] p;
    p = a * b;
    p = p >>> sh;
    if (p > 96'(ACC_MAX)) begin
      return ACC_MAX;
    end else if (p < 96'(ACC_MIN)) begin
      return ACC_MIN;
    end
    return p[ACC_W-1:0];
  endfunction

  function automatic logic signed [ACC_W-1:0] clamp(input logic signed [ACC_W-1:0] x,
                                                    input logic signed [ACC_W-1:0] lo,
                                                    input logic signed [ACC_W-1:0] hi);
    if (x < lo) begin
      return lo;
    end else if (x > hi) begin
      return hi;
    end
    return x;
  endfunction

  // saturating add; operands stay well inside the range so one guard bit suffices
  function automatic logic signed [ACC_W-1:0] sadd(input logic signed [ACC_W-1:0] a,
                                                   input logic signed [ACC_W-1:0] b);
    logic signed [ACC_W:0] s;
    s = {a[ACC_W-1], a} + {b[ACC_W-1], b};
    if (s > 49'(ACC_MAX)) begin
      return ACC_MAX;
    end else if (s < 49'(ACC_MIN)) begin
      return ACC_MIN;
    end
    return s[ACC_W-1:0];
  endfunction

  function automatic logic signed [ACC_W-1:0] ext_u(input logic [31:0] x);
    return $signed({16'h0000, x});
  endfunction

  function automatic logic signed [ACC_W-1:0] ext_s(input logic signed [COEF_W-1:0] x);
    return ACC_W'(x);
  endfunction

  // second and third order terms of one region, normalised to full scale
  function automatic logic signed [ACC_W-1:0] pow_term(input logic signed [ACC_W-1:0] p,
                                                       input logic signed [COEF_W-1:0] k,
                                                       input logic cube);
    logic signed [ACC_W-1:0] q;
    q = mulsh(p, p, CAP_W);
    if (cube) begin
      q = mulsh(q, p, CAP_W);
    end
    return mulsh(q, ext_s(k), NL_FRAC);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // state

  typedef struct packed {
    ccm_state_t state;
    logic [TEMP_W-1:0] raw_t;
    logic neg;
    logic [REM_W-2:0] den;
    logic [DIV_W-1:0] quo;
    logic [REM_W-1:0] rem;
    logic [5:0] cnt;
    logic [CAP_W-1:0] cap;
    logic signed [COEF_W-1:0] temp;
    logic done;
  } ccm_regs_t;

  localparam logic signed [ACC_W-1:0] HALF_SCALE = ACC_W'(1) <<< (CAP_W - 1);
  localparam logic signed [ACC_W-1:0] FULL_SCALE = (ACC_W'(1) <<< CAP_W) - ACC_W'(1);

  ccm_regs_t r_reg;
  ccm_regs_t r_next;
  logic [TEMP_W-1:0] t_masked;
  logic signed [ACC_W-1:0] dt;
  logic signed [ACC_W-1:0] num;
  logic signed [ACC_W-1:0] den;
  logic signed [ACC_W-1:0] mag;
  logic signed [ACC_W-1:0] adj;
  logic signed [ACC_W-1:0] raw1;
  logic signed [ACC_W-1:0] raw2;
  logic signed [ACC_W-1:0] p1;
  logic signed [ACC_W-1:0] p2;
  logic signed [ACC_W-1:0] cap_sum;
  logic signed [ACC_W-1:0] rt;
  logic signed [ACC_W-1:0] t_sum;
  logic [REM_W-1:0] rem_sh;

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    r_next = r_reg;
    r_next.done = 1'b0;
    t_masked = '0;
    dt = '0;
    num = '0;
    den = '0;
    mag = '0;
    adj = '0;
    raw1 = '0;
    raw2 = '0;
    p1 = '0;
    p2 = '0;
    cap_sum = '0;
    rt = '0;
    t_sum = '0;
    rem_sh = '0;
    unique case (r_reg.state)
      S_IDLE: begin
        if (i_start) begin
          unique case (i_temp_res) // see RL13
            TRES_8: t_masked = i_raw_temp & TMASK_8;
            TRES_10: t_masked = i_raw_temp & TMASK_10;
            TRES_12: t_masked = i_raw_temp & TMASK_12;
            TRES_14: t_masked = i_raw_temp & TMASK_14;
          endcase
          r_next.raw_t = t_masked; // see RL15
          dt = ext_u(32'(t_masked)) - ext_u(32'(i_reference_temp_reading)); // see RL7
          // offset pivots about mid-scale, so it is removed before the gain divide
          num = ext_u(32'(i_raw_cap)) - HALF_SCALE + ext_s(i_offset); // see RL11
          // no limit is applied to the loaded drift coefficients; sadd and mulsh saturate these terms
          num = sadd(num, mulsh(dt, sadd(ext_s(i_offset_drift_linear),
                     mulsh(dt, ext_s(i_offset_drift_square), DRIFT_SQ_FRAC)), DRIFT_LIN_FRAC)); // see RL2, RL12
          den = sadd(DEN_ONE, mulsh(dt, sadd(ext_s(i_slope_drift_linear),
                     mulsh(dt, ext_s(i_slope_drift_square), DRIFT_SQ_FRAC)), DRIFT_LIN_FRAC)); // see RL2
          num = clamp(num, -NUM_LIM, NUM_LIM); // see RL14
          den = clamp(den, DEN_MIN, DEN_MAX); // see RL14
          mag = num[ACC_W-1] ? -num : num;
          r_next.neg = num[ACC_W-1];
          r_next.quo = DIV_W'(mag <<< DEN_FRAC);
          r_next.den = den[REM_W-2:0];
          r_next.rem = '0;
          r_next.cnt = '0;
          r_next.state = S_DIV;
        end
      end
      S_DIV: begin
        // bit-serial divide trades 40 cycles for one shared subtractor
        rem_sh = {r_reg.rem[REM_W-2:0], r_reg.quo[DIV_W-1]};
        r_next.quo = {r_reg.quo[DIV_W-2:0], 1'b0};
        if (rem_sh >= {1'b0, r_reg.den}) begin
          r_next.rem = rem_sh - {1'b0, r_reg.den};
          r_next.quo[0] = 1'b1;
        end else begin
          r_next.rem = rem_sh;
        end
        r_next.cnt = r_reg.cnt + 6'h01;
        if (r_reg.cnt == DIV_STEPS - 6'h01) begin
          r_next.state = S_POLY;
        end
      end
      S_POLY: begin
        mag = $signed({8'h00, r_reg.quo});
        adj = sadd(r_reg.neg ? -mag : mag, HALF_SCALE); // see RL2, RL11
        adj = clamp(adj, -FULL_SCALE, FULL_SCALE << 1); // see RL14
        p1 = mulsh(ext_s(i_first_region_slope), i_mode_cubic ? adj :
                   clamp(adj, ACC_MIN, ext_u(32'(i_region_split_point))), GAIN_FRAC); // see RL3
        if (i_mode_cubic) begin // see RL1
          // second slope unused; its square slot holds the cubic coefficient
          cap_sum = sadd(sadd(pow_term(p1, i_second_region_square_coef, 1'b1),
                              pow_term(p1, i_first_region_square_coef, 1'b0)), p1); // see RL5, RL6
        end else begin
          raw1 = clamp(adj, ACC_MIN, ext_u(32'(i_region_split_point))); // see RL3
          raw2 = clamp(adj - ext_u(32'(i_region_split_point)), '0, ACC_MAX); // see RL3
          p2 = mulsh(ext_s(i_second_region_slope), raw2, GAIN_FRAC);
          cap_sum = sadd(sadd(pow_term(p1, i_first_region_square_coef, 1'b0), p1),
                         sadd(pow_term(p2, i_second_region_square_coef, 1'b0), p2)); // see RL4
        end
        r_next.cap = CAP_W'(clamp(cap_sum, '0, FULL_SCALE)); // see RL14
        rt = ext_u(32'(r_reg.raw_t)); // see RL9
        t_sum = sadd(mulsh(ext_s(i_temp_square_coef), mulsh(rt, rt, 0), TEMP_SQ_FRAC),
                     mulsh(ext_s(i_temp_slope_coef), rt, TEMP_GAIN_FRAC)); // see RL8
        t_sum = sadd(t_sum, ext_s(i_temp_offset_coef)); // see RL8
        r_next.temp = COEF_W'(clamp(t_sum, TEMP_OUT_MIN, TEMP_OUT_MAX)); // see RL10
        r_next.done = 1'b1; // see RL15
        r_next.state = S_IDLE;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      r_reg <= '{state: S_IDLE, default: '0};
    end else begin
      r_reg <= r_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  // results hold between runs; only done marks them fresh
  assign o_busy = (r_reg.state != S_IDLE);
  assign o_done = r_reg.done; // see RL15
  assign o_corr_cap = r_reg.cap;
  assign o_corr_temp = r_reg.temp;

endmodule

// ==== verification/ccm_correction_math_assertions.sv ====
// Purpose: handshake and timing checks on the correction datapath
// Assumes: one clock, synchronous reset
// Notes: result values are judged by the bench
module ccm_correction_math_assertions #(
  parameter int CAP_W = 14
) (
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst,
  // run control
  input wire logic i_start,
  input wire logic o_busy,
  input wire logic o_done,
  // results
  input wire logic [CAP_W-1:0] o_corr_cap,
  input wire logic signed [ccm_pkg::COEF_W-1:0] o_corr_temp
);
  timeunit 1ns;
  timeprecision 1ns;
  ////////////////////////////////////////////////////////////////////////////
  // busy length counter, cleared whenever idle
  logic [5:0] busy_cnt_reg;
  always_ff @(posedge i_sys_clk) begin
    busy_cnt_reg <= (i_rst || !o_busy) ? 6'h00 : busy_cnt_reg + 6'h01;
  end
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);
  ////////////////////////////////////////////////////////////////////////////
  a_done_latency: assert property ((i_start && !o_busy) |-> ##42 o_done)
    else $error("done not 42 cycles after start");
  a_busy_count: assert property (o_done |-> busy_cnt_reg == 6'h29)
    else $error("busy span before done not 41 cycles");
  a_start_taken: assert property ((i_start && !o_busy) |=> o_busy)
    else $error("start not taken");
  a_idle_stays: assert property ((!o_busy && !i_start) |=> !o_busy && !o_done)
    else $error("run began without start");
  a_done_pulse: assert property (o_done |=> !o_done)
    else $error("done longer than one cycle");
  a_done_frees: assert property (o_done |-> !o_busy)
    else $error("busy still high with done");
  a_results_hold: assert property ((!o_done && !$past(i_rst)) |-> $stable(o_corr_cap) && $stable(o_corr_temp))
    else $error("results moved outside done");
  a_reset_clear: assert property (disable iff (1'b0) i_rst |=> !o_busy && !o_done && o_corr_cap == '0 && o_corr_temp == '0)
    else $error("outputs not cleared by reset");
  c_start: cover property (i_start && !o_busy);
  c_refused: cover property (i_start && o_busy);
  c_done: cover property (o_done);
  c_reset_busy: cover property (disable iff (1'b0) i_rst && o_busy);
endmodule
bind ccm_correction_math ccm_correction_math_assertions #(.CAP_W(CAP_W)) u_ccm_chk (
  .i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_start(i_start), .o_busy(o_busy), .o_done(o_done),
  .o_corr_cap(o_corr_cap), .o_corr_temp(o_corr_temp));

// ==== verification/ccm_coef_store.sv ====
// Purpose: coefficient storage model feeding the correction datapath
// Assumes: a set is selected by index and held through a whole run
// Notes: order is offset, drifts, split, then slope and square/cubic for each region, temperature terms
module ccm_coef_store (
  // selection
  input wire logic [2:0] i_set,
  // coefficients
  output logic [15:0] o_c [0:12]
);
  timeunit 1ns;
  timeprecision 1ns;
  ////////////////////////////////////////////////////////////////////////////
  // drift terms kept small so the arithmetic never nears saturation
  localparam logic [15:0] SETS [0:4][0:12] = '{
    '{16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h2EE0, 16'h4000, 16'h0000, 16'h4000,
      16'h0000, 16'h0000, 16'h4000, 16'h0000},
    '{16'hF830, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0FA0, 16'h4000, 16'h0000, 16'h0000,
      16'h0000, 16'h0000, 16'h0000, 16'hFF9C},
    '{16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h3FFF, 16'h4000, 16'h4000, 16'h4000,
      16'h0000, 16'h4000, 16'h0000, 16'h0000},
    '{16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0064, 16'h4000, 16'h4000, 16'h7FFF,
      16'h4000, 16'h0000, 16'h7FFF, 16'h03E8},
    '{16'h0000, 16'h4000, 16'h0000, 16'h4000, 16'h0000, 16'h3FFF, 16'h4000, 16'h0000, 16'h4000,
      16'h0000, 16'h0000, 16'h4000, 16'h8000}};
  assign o_c = SETS[i_set];
endmodule

// ==== verification/tb_top.sv ====
// Purpose: self-checking bench for the correction datapath
// Assumes: coefficients come from the storage model, the reference temperature reading from the bench, and hold through each run
// Notes: expected values worked out by hand from the fixed-point choices
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct {logic [2:0] s; logic m; logic [1:0] r; logic [13:0] cap, rt, ec; logic [15:0] et;} ccm_row_t;
  logic i_sys_clk = 1'b0;
  logic i_rst = 1'b1;
  logic i_start = 1'b0;
  logic mode = 1'b0;
  logic [1:0] res = 2'h0;
  logic [2:0] set = 3'h0;
  logic [13:0] cap = 14'h0000;
  logic [13:0] rt = 14'h0000;
  logic [13:0] ref_t = 14'h0000;
  logic o_busy, o_done;
  logic [13:0] o_corr_cap;
  logic [15:0] o_corr_temp;
  logic [15:0] c [0:12];
  int n_fail = 0;
  int checks = 0;
  int cyc = 0;
  int n;
  // set, cubic, resolution, raw cap, raw temp, expected cap, expected temp
  ccm_row_t rows [0:8] = '{
    '{3'h0, 1'b0, 2'h1, 14'h1388, 14'h3C2C, 14'h1388, 16'h002C}, '{3'h0, 1'b0, 2'h3, 14'h32C8, 14'h3FFF, 14'h32C8, 16'h3FFF},
    '{3'h0, 1'b0, 2'h0, 14'h0000, 14'h3FFF, 14'h0000, 16'h00FF}, '{3'h0, 1'b0, 2'h2, 14'h3FFF, 14'h3FFF, 14'h3FFF, 16'h0FFF},
    '{3'h1, 1'b0, 2'h3, 14'h1F40, 14'h0000, 14'h0FA0, 16'hFF9C}, '{3'h1, 1'b0, 2'h3, 14'h03E8, 14'h0000, 14'h0000, 16'hFF9C},
    '{3'h2, 1'b0, 2'h3, 14'h2000, 14'h1000, 14'h2800, 16'h4000}, '{3'h3, 1'b1, 2'h3, 14'h2000, 14'h3FFF, 14'h2C00, 16'h7FFF},
    '{3'h4, 1'b0, 2'h3, 14'h2000, 14'h0400, 14'h20FC, 16'h8400}};
  ////////////////////////////////////////////////////////////////////////////
  ccm_coef_store u_ccm_coef_store (.i_set(set), .o_c(c));
  ccm_correction_math u_ccm_correction_math (
    .i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_start(i_start), .i_mode_cubic(mode), .i_temp_res(res),
    .o_busy(o_busy), .o_done(o_done), .i_raw_cap(cap), .i_raw_temp(rt), .i_offset(c[0]),
    .i_offset_drift_linear(c[1]), .i_offset_drift_square(c[2]), .i_slope_drift_linear(c[3]),
    .i_slope_drift_square(c[4]), .i_reference_temp_reading(ref_t), .i_region_split_point(c[5][13:0]),
    .i_first_region_slope(c[6]), .i_first_region_square_coef(c[7]), .i_second_region_slope(c[8]),
    .i_second_region_square_coef(c[9]), .i_temp_square_coef(c[10]), .i_temp_slope_coef(c[11]),
    .i_temp_offset_coef(c[12]), .o_corr_cap(o_corr_cap), .o_corr_temp(o_corr_temp));
  always #20 i_sys_clk = ~i_sys_clk;
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD %0t saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic stop_test();
    if (n_fail == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic load(input int k);
    set <= rows[k].s;
    mode <= rows[k].m;
    res <= rows[k].r;
    cap <= rows[k].cap;
    rt <= rows[k].rt;
  endtask
  task automatic wait_done();
    for (n = 1; n < 60 && o_done !== 1'b1; n++) begin
      @(posedge i_sys_clk);
      #1;
    end
    chk({15'h0000, o_done}, 16'h0001);
  endtask
  task automatic check_row(input int k);
    chk({2'h0, o_corr_cap}, {2'h0, rows[k].ec});
    chk(o_corr_temp, rows[k].et);
  endtask
  // hang guard: all runs need well under 1000 cycles
  always @(posedge i_sys_clk) begin
    cyc++;
    if (cyc == 1500) begin
      n_fail++;
      stop_test();
    end
  end
  initial begin
    repeat (4) @(posedge i_sys_clk);
    i_rst <= 1'b0;
    @(posedge i_sys_clk);
    #1;
    chk({o_busy, o_done, o_corr_cap}, 16'h0000);
    chk(o_corr_temp, 16'h0000);
    for (int k = 0; k < 9; k++) begin
      @(posedge i_sys_clk);
      load(k);
      i_start <= 1'b1;
      @(posedge i_sys_clk);
      i_start <= 1'b0;
      wait_done();
      check_row(k);
    end
    // start held high: new inputs mid-run are refused, restart follows done
    @(posedge i_sys_clk);
    // same coefficient set both runs; only the raw reading moves mid-run
    load(4);
    i_start <= 1'b1;
    @(posedge i_sys_clk);
    load(5);
    wait_done();
    check_row(4);
    for (n = 1; n < 60; n++) begin
      @(posedge i_sys_clk);
      #1;
      if (o_done === 1'b1) break;
    end
    chk(16'(n), 16'h002A);
    check_row(5);
    // third run starts at once; reset cuts it short
    repeat (5) @(posedge i_sys_clk);
    i_start <= 1'b0;
    i_rst <= 1'b1;
    repeat (2) @(posedge i_sys_clk);
    i_rst <= 1'b0;
    // start in the first cycle after release; reference equal to raw temp cancels drift
    load(8);
    ref_t <= 14'h0400;
    i_start <= 1'b1;
    #1;
    chk({o_busy, o_done, o_corr_cap}, 16'h0000);
    chk(o_corr_temp, 16'h0000);
    @(posedge i_sys_clk);
    i_start <= 1'b0;
    wait_done();
    chk({2'h0, o_corr_cap}, 16'h2000);
    chk(o_corr_temp, 16'h8400);
    stop_test();
  end
endmodule
